// ---- hdl/qdd_defines.svh ----
// Purpose: Offsets, field positions, reset values and widths of the output word decoder.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus.
// Notes: Definitions only.
`ifndef QDD_DEFINES_SVH
`define QDD_DEFINES_SVH

`define QDD_ADR_WORD     8'h00
`define QDD_ADR_FORMAT   8'h04
`define QDD_ADR_CODE12   8'h08
`define QDD_ADR_CODE34   8'h0C
`define QDD_ADR_STATUS   8'h10
`define QDD_ADR_COUNT    8'h14

`define QDD_WORD_W       16
`define QDD_DATA_W       12
`define QDD_NCH          4
`define QDD_SEL_LO       12
`define QDD_SEL_HI       13
`define QDD_EN_BIT       14
`define QDD_SIGN_BIT     15
`define QDD_MAG_TOP      11

`define QDD_WORD_RST     16'h0000
`define QDD_FORMAT_RST   4'h0
`define QDD_CODE_ZERO    12'h000
`define QDD_CODE_MID     12'h800
`define QDD_COUNT_RST    16'h0000

`endif

// ---- hdl/qdd_pkg.sv ----
// Purpose: Types shared by the output word decoder files.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes: Constants live in qdd_defines.svh.
package qdd_pkg;

    typedef enum logic
    {
        QDD_FMT_UNSIGNED = 1'b0,
        QDD_FMT_SIGNED   = 1'b1
    } qdd_fmt_t;

    typedef enum logic [1:0]
    {
        QDD_CH1 = 2'b00,
        QDD_CH2 = 2'b01,
        QDD_CH3 = 2'b10,
        QDD_CH4 = 2'b11
    } qdd_chan_t;

endpackage

// ---- hdl/qdd_word_decode.sv ----
// Purpose: Splits one 16-bit output word into selector, sample, sign and enable.
// Assumes: Purely combinational; the caller registers the results.
// Notes: The selector has no idle code, so exactly one strobe bit is always set.
`timescale 1ns/1ps
`default_nettype none
`include "qdd_defines.svh"

module qdd_word_decode
(
    input  wire logic [15:0] word_i,
    output logic      [3:0]  chan_hot_o,
    output qdd_pkg::qdd_chan_t chan_o,
    output logic      [11:0] data_o,
    output logic             sign_o,
    output logic             enable_o
);

    assign chan_o     = qdd_pkg::qdd_chan_t'(word_i[`QDD_SEL_HI:`QDD_SEL_LO]); // R1
    assign chan_hot_o = 4'h1 << word_i[`QDD_SEL_HI:`QDD_SEL_LO]; // R3
    assign data_o     = word_i[`QDD_MAG_TOP:0]; // R4
    assign sign_o     = word_i[`QDD_SIGN_BIT]; // R5
    assign enable_o   = word_i[`QDD_EN_BIT]; // R9

endmodule
`default_nettype wire

// ---- hdl/qdd_channel.sv ----
// Purpose: One output channel: holding register and format conversion to a converter code.
// Assumes: Converter code 0 is the bottom and 4095 the top of the channel's range.
// Notes: The code follows the stored sample and format one clock later.
`timescale 1ns/1ps
`default_nettype none
`include "qdd_defines.svh"

module qdd_channel
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        load_i,
    input  wire logic        clear_i,
    input  wire logic [11:0] data_i,
    input  wire logic        sign_i,
    input  wire logic        signed_fmt_i,
    output logic      [11:0] sample_o,
    output logic             sample_sign_o,
    output logic      [11:0] code_o
);

    // Bit 11 set in signed format is not saturated: the low eleven bits count up from
    // the bottom again, so software that overshoots 2047 sees a jump to the range bottom.
    function automatic logic [11:0] conv(input logic [11:0] d, input logic s,
                                         input logic sf);
        logic [11:0] mag;
        mag = {1'b0, d[10:0]};
        if (!sf)
            conv = d; // R12 R16
        else if (d[`QDD_MAG_TOP])
            conv = mag; // R7
        else if (s)
            conv = `QDD_CODE_MID - mag; // R5
        else
            conv = `QDD_CODE_MID + mag;
    endfunction

    wire logic [11:0] next_code;
    assign next_code = conv(sample_o, sample_sign_o, signed_fmt_i); // R15

    always_ff @(posedge clk_i)
    begin
        if (rst_i || clear_i)
        begin
            sample_o      <= `QDD_CODE_ZERO; // R10
            sample_sign_o <= 1'b0;
        end
        else if (load_i)
        begin
            sample_o      <= data_i; // R2
            sample_sign_o <= sign_i;
        end
    end // R17

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            code_o <= `QDD_CODE_ZERO;
        else
            code_o <= next_code;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_unsigned_map: assert property (!$past(signed_fmt_i) && !$past(rst_i)
        |-> code_o == $past(sample_o)) else $error("unsigned code mismatch"); // R12

    a_signed_wrap: assert property ($past(signed_fmt_i) && $past(sample_o[11]) && !$past(rst_i)
        |-> code_o == {1'b0, $past(sample_o[10:0])}) else $error("signed wrap wrong"); // R7

    a_signed_neg: assert property ($past(signed_fmt_i) && !$past(sample_o[11])
        && $past(sample_sign_o) && !$past(rst_i)
        |-> code_o == 12'h800 - {1'b0, $past(sample_o[10:0])}) else $error("negative code wrong"); // R5

    a_hold_zero: assert property (!load_i && sample_o == 12'h000 |=> sample_o == 12'h000)
        else $error("idle channel left zero"); // R11

endmodule
`default_nettype wire

// ---- hdl/qdd_top.sv ----
// Purpose: Four-channel analog output word decoder behind a classic Wishbone slave.
// Assumes: Software writes the 16-bit output word once per scan; format bits are static-ish.
// Notes: Each register access is acked one cycle after the request; writes land with ack.
//
// Functional notes
// [R1] Word bits 13:12 pick channel 1 to 4 in binary order.
// [R2] Each scan update loads the word's sample into the selected channel.
// [R3] No idle selector code; every update writes exactly one channel.
// [R4] Word bits 11:0 form the unsigned sample magnitude.
// [R5] In signed format word bit 15 is the sample sign.
// [R6] Controller keeps data bit 11 clear for signed-format channels.
// [R7] Signed magnitudes above 2047 wrap to the range bottom, no saturation.
// [R8] Controller never commands signed values beyond plus or minus 2047.
// [R9] Word bit 14 enables all four channel outputs.
// [R10] Enable clear forces zero output and clears all stored samples.
// [R11] After enable rises a channel stays zero until written non-zero.
// [R12] Unsigned code 0 is range bottom, 4095 is full scale, linear.
// [R13] Host interface is one 16-bit contiguous output word.
// [R14] Controller may write channels in any order, several per scan.
// [R15] Each channel has its own format, signed or unsigned.
// [R16] Unsigned-format channels ignore the sign bit.
// [R17] A channel holds its sample until reselected or enable clears.
`timescale 1ns/1ps
`default_nettype none
`include "qdd_defines.svh"

module qdd_top
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic      [11:0] ch1_code_o,
    output logic      [11:0] ch2_code_o,
    output logic      [11:0] ch3_code_o,
    output logic      [11:0] ch4_code_o,
    output logic             out_enable_o
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    logic [15:0] word;
    logic [3:0]  format;
    logic [15:0] scan_count;
    logic [3:0]  written;
    qdd_pkg::qdd_chan_t last_chan;

    wire logic        req;
    wire logic        wr_ack;
    wire logic        hit_word;
    wire logic        hit_format;
    wire logic        hit_code12;
    wire logic        hit_code34;
    wire logic        hit_status;
    wire logic        hit_count;
    wire logic [15:0] next_word;
    wire logic        upd;

    assign req        = wb_cyc_i && wb_stb_i;
    assign wr_ack     = req && wb_we_i && wb_ack_o;
    assign hit_word   = wb_adr_i == `QDD_ADR_WORD;
    assign hit_format = wb_adr_i == `QDD_ADR_FORMAT;
    assign hit_code12 = wb_adr_i == `QDD_ADR_CODE12;
    assign hit_code34 = wb_adr_i == `QDD_ADR_CODE34;
    assign hit_status = wb_adr_i == `QDD_ADR_STATUS;
    assign hit_count  = wb_adr_i == `QDD_ADR_COUNT;

    // The word is sixteen output points; unselected byte lanes keep their old value.
    assign next_word  = {wb_sel_i[1] ? wb_dat_i[15:8] : word[15:8],
                         wb_sel_i[0] ? wb_dat_i[7:0]  : word[7:0]}; // R13

    // Any write that touches the word counts as one scan update.
    assign upd        = wr_ack && hit_word && (wb_sel_i[1:0] != 2'b00);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Word decode of the incoming update.

    wire logic [3:0]  chan_hot;
    wire logic [11:0] dec_data;
    wire logic        dec_sign;
    wire logic        dec_enable;
    qdd_pkg::qdd_chan_t dec_chan;

    qdd_word_decode u_dec
    (
        .word_i     (next_word),
        .chan_hot_o (chan_hot),
        .chan_o     (dec_chan),
        .data_o     (dec_data),
        .sign_o     (dec_sign),
        .enable_o   (dec_enable)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // Register file.

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req && !wb_ack_o;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            word <= `QDD_WORD_RST;
        else if (upd)
            word <= next_word;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            format <= `QDD_FORMAT_RST;
        else if (wr_ack && hit_format && wb_sel_i[0])
            format <= wb_dat_i[3:0]; // R15
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            out_enable_o <= 1'b0;
        else if (upd)
            out_enable_o <= dec_enable; // R9
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            last_chan <= qdd_pkg::QDD_CH1;
        else if (upd)
            last_chan <= dec_chan; // R1
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            scan_count <= `QDD_COUNT_RST;
        else if (upd)
            scan_count <= scan_count + 16'h0001;
    end

    // Tracks which channels have been loaded with a non-zero sample since enable rose.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (upd && !dec_enable))
            written <= 4'h0; // R10
        else if (upd && dec_data != `QDD_CODE_ZERO)
            written <= written | chan_hot; // R11
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Channels.

    wire logic [11:0] sample [0:3];
    wire logic [3:0]  sample_sign;
    wire logic [11:0] code   [0:3];
    wire logic        clear_all;

    // Disable is handled both on the updating write and while it stays off, so a
    // stray load can never slip past a disabled module.
    assign clear_all = (upd && !dec_enable) || (!out_enable_o && !upd); // R10

    genvar k;
    generate
        for (k = 0; k < `QDD_NCH; k = k + 1)
        begin : g_ch
            qdd_channel u_ch
            (
                .clk_i         (clk_i),
                .rst_i         (rst_i),
                .load_i        (upd && dec_enable && chan_hot[k]),
                .clear_i       (clear_all),
                .data_i        (dec_data),
                .sign_i        (dec_sign),
                .signed_fmt_i  (format[k]),
                .sample_o      (sample[k]),
                .sample_sign_o (sample_sign[k]),
                .code_o        (code[k])
            ); // R2 R3
        end
    endgenerate

    assign ch1_code_o = code[0];
    assign ch2_code_o = code[1];
    assign ch3_code_o = code[2];
    assign ch4_code_o = code[3];

    ////////////////////////////////////////////////////////////////////////////////////////
    // Read data.

    wire logic [31:0] rd_mux;

    assign rd_mux = hit_word   ? {16'h0000, word} :
                    hit_format ? {28'h000_0000, format} :
                    hit_code12 ? {4'h0, code[1], 4'h0, code[0]} :
                    hit_code34 ? {4'h0, code[3], 4'h0, code[2]} :
                    hit_status ? {16'h0000, sample_sign, written, 2'b00, last_chan,
                                  3'b000, out_enable_o} :
                    hit_count  ? {16'h0000, scan_count} :
                                 32'h0000_0000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (req && !wb_ack_o && !wb_we_i)
            wb_dat_o <= rd_mux;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_ack_after_req: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");

    a_one_hot_select: assert property (upd |-> $onehot(chan_hot)) // R3
        else $error("selector did not pick exactly one channel");

    a_select_order: assert property (upd |-> chan_hot == (4'h1 << next_word[13:12])) // R1
        else $error("selector mapping wrong");

    a_load_selected: assert property (upd && next_word[14] |=> // R2
        sample[$past(next_word[13:12])] == $past(next_word[11:0]))
        else $error("selected channel not loaded");

    a_hold_others: assert property (upd && next_word[14] // R17
        && next_word[13:12] != 2'b00 |=> $stable(sample[0]))
        else $error("unselected channel 1 changed");

    a_disable_clears: assert property (upd && !next_word[14] |=> !out_enable_o // R10
        && sample[0] == 12'h000 && sample[1] == 12'h000
        && sample[2] == 12'h000 && sample[3] == 12'h000)
        else $error("disable did not clear channels");

    a_enable_follow: assert property (upd |=> out_enable_o == $past(next_word[14])) // R9
        else $error("enable not taken from bit 14");

    a_disabled_stays: assert property (!out_enable_o && !upd ##1 !out_enable_o // R10
        |-> sample[0] == 12'h000 && sample[1] == 12'h000 && sample[2] == 12'h000
        && sample[3] == 12'h000)
        else $error("disabled channel not at zero");

    a_unsigned_data: assert property (upd && next_word[14] && !format[next_word[13:12]] // R4
        |=> sample[$past(next_word[13:12])] == $past(next_word[11:0]))
        else $error("sample magnitude not bits 11 to 0");

    a_sel_ch1: assert property (upd && next_word[13:12] == 2'b00 // R1
        |-> chan_hot == 4'b0001)
        else $error("code 00 did not select channel 1");

    a_sel_ch2: assert property (upd && next_word[13:12] == 2'b01 // R1
        |-> chan_hot == 4'b0010)
        else $error("code 01 did not select channel 2");

    a_sel_ch3: assert property (upd && next_word[13:12] == 2'b10 // R1
        |-> chan_hot == 4'b0100)
        else $error("code 10 did not select channel 3");

    a_sel_ch4: assert property (upd && next_word[13:12] == 2'b11 // R1
        |-> chan_hot == 4'b1000)
        else $error("code 11 did not select channel 4");

    a_hold_ch2: assert property (upd && next_word[14] // R17
        && next_word[13:12] != 2'b01 |=> $stable(sample[1]))
        else $error("unselected channel 2 changed");

    a_hold_ch3: assert property (upd && next_word[14] // R17
        && next_word[13:12] != 2'b10 |=> $stable(sample[2]))
        else $error("unselected channel 3 changed");

    a_hold_ch4: assert property (upd && next_word[14] // R17
        && next_word[13:12] != 2'b11 |=> $stable(sample[3]))
        else $error("unselected channel 4 changed");

    a_hold_idle: assert property (!upd && out_enable_o |=> $stable(sample[0]) // R17
        && $stable(sample[1]) && $stable(sample[2]) && $stable(sample[3]))
        else $error("channel changed without an update");

    a_sign_store: assert property (upd && next_word[14] // R5
        |=> sample_sign[$past(next_word[13:12])] == $past(next_word[15]))
        else $error("sign not stored with the sample");

    a_sign_cleared: assert property (upd && !next_word[14] // R10
        |=> sample_sign == 4'h0)
        else $error("disable did not clear stored signs");

    a_enable_hold: assert property (!upd // R9
        |=> $stable(out_enable_o))
        else $error("enable changed without an update");

    a_written_clear: assert property (upd && !next_word[14] // R10
        |=> written == 4'h0)
        else $error("written marks not cleared by disable");

    a_written_mark: assert property (upd && next_word[14] && next_word[11:0] != 12'h000 // R11
        |=> written[$past(next_word[13:12])])
        else $error("non-zero write not marked");

    a_code_follow1: assert property (!format[0] // R12
        |=> ch1_code_o == $past(sample[0]))
        else $error("unsigned channel 1 code not the sample");

    a_code_follow3: assert property (!format[2] // R12
        |=> ch3_code_o == $past(sample[2]))
        else $error("unsigned channel 3 code not the sample");

    a_off_code_uns: assert property (!out_enable_o && !upd ##1 !format[0] // R10
        |=> ch1_code_o == 12'h000)
        else $error("disabled unsigned channel not at zero code");

    a_off_code_sgn: assert property (!out_enable_o && !upd ##1 format[1] // R10
        |=> ch2_code_o == 12'h800)
        else $error("disabled signed channel not at midscale");

    a_ack_needs_req: assert property (!req
        |=> !wb_ack_o)
        else $error("ack without a request");

    a_rdata_hold: assert property (!(req && !wb_ack_o && !wb_we_i)
        |=> $stable(wb_dat_o))
        else $error("read data changed without a read");

    a_count_step: assert property (upd
        |=> scan_count == $past(scan_count) + 16'h0001)
        else $error("update counter did not step");

    a_format_hold: assert property (!(wr_ack && hit_format) // R15
        |=> $stable(format))
        else $error("format changed without a write");

endmodule
`default_nettype wire

// ---- bench/qdd_cpu_model.sv ----
// Purpose: Controller side of the output word decoder, a classic Wishbone bus master.
// Assumes: The slave acks every request; no wait state count is assumed.
// Notes: A request that draws no ack within the bound raises hang_o.
`timescale 1ns/1ps
`default_nettype none

module qdd_cpu_model
(
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] rdat_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic      [7:0]  adr_o,
    output logic      [3:0]  sel_o,
    output logic      [31:0] dat_o,
    output logic             hang_o
);
    initial
    begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0000_0000;
        hang_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // The request stands unchanged until ack is seen high at a rising edge.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'hf;
        dat_o <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_i !== 1'b1 && n < 20);
        if (ack_i !== 1'b1)
            hang_o <= 1'b1;
        q = rdat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        // Released address and data lines show the inverse so stale values cannot pass for a hold.
        adr_o <= ~a;
        dat_o <= ~d;
    endtask
endmodule

`default_nettype wire

// ---- bench/qdd_top_tb.sv ----
// Purpose: Self-checking bench for the output word decoder against a behavioural model.
// Assumes: Codes appear one edge after the ack edge of a word or format write.
// Notes: Signed channels get bit 11 cleared in random words, as the controller must.
`timescale 1ns/1ps
`default_nettype none
`include "qdd_defines.svh"

module qdd_top_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc, stb, we, ack, en_o, hang;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [11:0] c1, c2, c3, c4;
    logic [15:0] w;
    logic [15:0] tbl [8];
    int          n_errors = 0;
    int          tests_run = 0;
    int          samp [4];
    int          sgn [4];
    int          fmt = 0;
    int          en = 0;
    int          seed = 32'h7e93d739;
    int          cnt = 0;
    int          last = 0;
    int          wrt = 0;
    logic [15:0] lw = 16'h0000;

    always #2.5 clk_i = ~clk_i;

    qdd_top qdd_top_inst
    (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ch1_code_o(c1), .ch2_code_o(c2), .ch3_code_o(c3), .ch4_code_o(c4),
        .out_enable_o(en_o)
    );

    qdd_cpu_model qdd_cpu_model_inst
    (
        .clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .sel_o(sel), .dat_o(wdat), .hang_o(hang)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (n_errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [11:0] mcode(input int c);
        logic [11:0] m;
        m = samp[c][11:0];
        if (fmt[c] == 0)
            return m;
        if (m[11])
            return {1'b0, m[10:0]};
        return (sgn[c] != 0) ? 12'h800 - m : 12'h800 + m;
    endfunction

    function automatic logic [31:0] mstat();
        logic [3:0] s;
        for (int i = 0; i < 4; i++)
            s[i] = (sgn[i] != 0);
        return {16'h0000, s, wrt[3:0], 2'b00, last[1:0], 3'b000, en[0]};
    endfunction

    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
        chk("ch1", {20'h0, mcode(0)}, {20'h0, c1});
        chk("ch2", {20'h0, mcode(1)}, {20'h0, c2});
        chk("ch3", {20'h0, mcode(2)}, {20'h0, c3});
        chk("ch4", {20'h0, mcode(3)}, {20'h0, c4});
        chk("enable", en, {31'h0, en_o});
    endtask

    task automatic word(input logic [15:0] v);
        qdd_cpu_model_inst.xfer(1'b1, `QDD_ADR_WORD, {16'h0000, v}, q);
        en = v[14];
        cnt++;
        lw = v;
        last = v[13:12];
        if (!v[14])
            wrt = 0;
        else if (v[11:0] != 12'h000)
            wrt[v[13:12]] = 1'b1;
        for (int i = 0; i < 4; i++)
            if (!v[14])
            begin
                samp[i] = 0;
                sgn[i] = 0;
            end
        if (v[14])
        begin
            samp[v[13:12]] = v[11:0];
            sgn[v[13:12]] = v[15];
        end
        settle();
    endtask

    task automatic setfmt(input int f);
        fmt = f;
        qdd_cpu_model_inst.xfer(1'b1, `QDD_ADR_FORMAT, f, q);
        settle();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        qdd_cpu_model_inst.xfer(1'b0, a, 32'h0000_0000, q);
        chk(nm, e, q);
    endtask

    task automatic rdall();
        rd(`QDD_ADR_STATUS, mstat(), "status");
        rd(`QDD_ADR_COUNT, cnt, "count");
        rd(`QDD_ADR_WORD, {16'h0000, lw}, "word");
    endtask

    always @(posedge hang)
    begin
        n_errors++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 4; i++)
        begin
            samp[i] = 0;
            sgn[i] = 0;
        end
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        settle();
        rd(`QDD_ADR_FORMAT, 32'h0000_0000, "format");
        rd(8'h18, 32'h0000_0000, "unmapped");
        for (int c = 0; c < 4; c++)
            word({2'b01, c[1:0], 12'hfff - 12'h3 * c[11:0]});
        word(16'h4000);
        rd(`QDD_ADR_CODE12, {4'h0, mcode(1), 4'h0, mcode(0)}, "code12");
        rd(`QDD_ADR_CODE34, {4'h0, mcode(3), 4'h0, mcode(2)}, "code34");
        setfmt(4'b1010);
        rd(`QDD_ADR_FORMAT, 32'h0000_000a, "format");
        tbl = '{16'h5005, 16'hd7ff, 16'h5000, 16'h7805, 16'hf7ff, 16'hc123, 16'h77ff, 16'h6abc};
        foreach (tbl[i])
            word(tbl[i]);
        word(16'h3abc);
        word(16'h0001);
        word(16'h4000);
        word(16'h5123);
        rdall();
        for (int k = 0; k < 40; k++)
        begin
            if (k % 10 == 0)
                setfmt($random(seed) & 15);
            w = 16'($random(seed));
            w[14] = (w[2:0] != 3'b000);
            if (fmt[w[13:12]])
                w[11] = 1'b0;
            word(w);
        end
        rdall();
        test_done();
    end
endmodule

`default_nettype wire
